// ===== hdl/slpp_pkg.sv
package slpp_pkg;

    // Serial word and destination select.
    localparam int        WORD_W     = 24;
    localparam logic [23:0] WORD_RESET = 24'h000000;
    localparam int        SEL_LSB    = 0;
    localparam logic [1:0] SEL_CTRL  = 2'h0;
    localparam logic [1:0] SEL_NDIV  = 2'h2;

    // Field positions in the control word.
    localparam int CB_CORE_LSB  = 2;
    localparam int CB_DIV_RESET = 4;
    localparam int CB_MON_LSB   = 5;
    localparam int CB_POLARITY  = 8;
    localparam int CB_PUMP_TRI  = 9;
    localparam int CB_GAIN      = 10;
    localparam int CB_MUTE      = 11;
    localparam int CB_LEVEL_LSB = 12;
    localparam int CB_PRI_LSB   = 14;
    localparam int CB_ALT_LSB   = 17;
    localparam int CB_PD_ARM    = 20;
    localparam int CB_PD_SYNC   = 21;
    localparam int CB_PRESC_LSB = 22;

    // Field positions in the feedback-divider word.
    localparam int NB_SWALLOW_LSB = 2;
    localparam int SWALLOW_W      = 5;
    localparam int NB_MAIN_LSB    = 8;
    localparam int MAIN_W         = 13;
    localparam int NB_GAIN        = 21;
    localparam int NB_HALVE       = 22;
    localparam int NB_PRESC_HALVE = 23;
    localparam logic [12:0] MAIN_MIN = 13'h0003;

    // Total division width and prescaler moduli for each select code.
    localparam int TOTAL_W = 19;
    localparam logic [5:0] PRESC_MOD0 = 6'h08;
    localparam logic [5:0] PRESC_MOD1 = 6'h10;
    localparam logic [5:0] PRESC_MOD2 = 6'h20;
    localparam logic [5:0] PRESC_MOD3 = 6'h20;

    // Reference-divider edge counts for band select and gated power-down.
    localparam logic [2:0] BAND_CYCLES   = 3'h5;
    localparam logic [1:0] SYNC_PD_EDGES = 2'h2;

    // Maps the prescaler select code onto its modulus.
    function automatic logic [5:0] presc_modulus(input logic [1:0] code);
        logic [5:0] m;
        m = PRESC_MOD0;
        case (code)
            2'h1:    m = PRESC_MOD1;
            2'h2:    m = PRESC_MOD2;
            2'h3:    m = PRESC_MOD3;
            default: m = PRESC_MOD0;
        endcase
        return m;
    endfunction

endpackage

// ===== hdl/slpp_sync3.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; the level follows once stages two and three agree.
module slpp_sync3 (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    logic [2:0] stage;

    // Shift the pin through the stages and accept agreed values.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage <= 3'h0;
            level <= 1'b0;
        end
        else if (clk_en)
        begin
            stage <= {stage[1:0], pin};
            if (stage[2] == stage[1])
                level <= stage[2];
        end
    end

    // One-cycle rising event, valid in the cycle before the level updates.
    assign rise = (stage[2] == stage[1]) & stage[2] & ~level;
endmodule

// ===== hdl/slpp_top.sv
`timescale 1ns/1ps
module slpp_top (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        load_strobe,
    input  wire logic        chip_enable,
    input  wire logic        ref_div_out,
    input  wire logic        lock_detect,
    output logic [23:0]      synth_control_word,
    output logic [23:0]      feedback_divider_word,
    output logic             pump_gain_select,
    output logic [2:0]       pump_current,
    output logic [18:0]      total_divide,
    output logic             main_count_valid,
    output logic [4:0]       swallow_count,
    output logic [12:0]      main_count,
    output logic             output_halve,
    output logic             prescaler_input_halve,
    output logic             detector_polarity,
    output logic [2:0]       monitor_select,
    output logic [1:0]       output_level,
    output logic [1:0]       core_current,
    output logic [1:0]       prescaler_select,
    output logic             powered_down,
    output logic             bias_enable,
    output logic             counters_hold,
    output logic             pump_tristate,
    output logic             lock_detect_reset,
    output logic             rf_output_enable,
    output logic             ref_buffer_enable,
    output logic             band_select_active
);
    logic [23:0] shift;
    logic        sclk_r, data_lvl, load_r;
    logic        ce_lvl, ref_r, lock_lvl;
    logic        ctrl_seen, sw_pd, pd_pending, band_valid, n_dirty, pd_prev;
    logic [1:0]  pd_edges;
    logic [2:0]  band_count;

    // Pin synchronisers for every input from outside the clock domain.
    slpp_sync3 u_sclk (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pin(serial_clk),
                       .level(), .rise(sclk_r));
    slpp_sync3 u_data (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pin(serial_data),
                       .level(data_lvl), .rise());
    slpp_sync3 u_load (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pin(load_strobe),
                       .level(), .rise(load_r));
    slpp_sync3 u_ce   (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pin(chip_enable),
                       .level(ce_lvl), .rise());
    slpp_sync3 u_ref  (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pin(ref_div_out),
                       .level(), .rise(ref_r));
    slpp_sync3 u_lock (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .pin(lock_detect),
                       .level(lock_lvl), .rise());

    // Event decode; the select bits sit in the two LSBs of the shifted word.
    wire       sclk_rise = clk_en & sclk_r;
    wire       load_rise = clk_en & load_r;
    wire       ref_rise  = clk_en & ref_r;
    wire [1:0] sel       = shift[slpp_pkg::SEL_LSB +: 2];
    wire       ctrl_load = load_rise & (sel == slpp_pkg::SEL_CTRL);
    wire       n_load    = load_rise & (sel == slpp_pkg::SEL_NDIV);
    wire       new_arm   = shift[slpp_pkg::CB_PD_ARM];
    wire       new_sync  = shift[slpp_pkg::CB_PD_SYNC];

    // Power state: no control word yet, software power-down or a low enable pin.
    wire device_pd   = ~ctrl_seen | sw_pd | ~ce_lvl;
    wire power_up    = clk_en & pd_prev & ~device_pd;
    wire band_start  = (n_load & ~device_pd) | (power_up & (~band_valid | n_dirty));
    wire ref_at_last = ref_rise & (pd_edges == slpp_pkg::SYNC_PD_EDGES - 2'h1);

    // Stored control fields.
    wire       mute_en  = synth_control_word[slpp_pkg::CB_MUTE];
    wire       div_rst  = synth_control_word[slpp_pkg::CB_DIV_RESET];
    wire       pump_tri = synth_control_word[slpp_pkg::CB_PUMP_TRI];
    wire [2:0] pri_cur  = synth_control_word[slpp_pkg::CB_PRI_LSB +: 3];
    wire [2:0] alt_cur  = synth_control_word[slpp_pkg::CB_ALT_LSB +: 3];
    wire [2:0] next_pump_current = pump_gain_select ? alt_cur : pri_cur;

    // Feedback division from the stored fields.
    wire [5:0]  modulus = slpp_pkg::presc_modulus(prescaler_select);
    wire [18:0] next_total_divide = 19'(19'(modulus) * 19'(main_count))
                                  + 19'(swallow_count);

    // The input register shifts on every serial clock rise, powered or not.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            shift <= slpp_pkg::WORD_RESET;
        else if (sclk_rise)
            shift <= {shift[22:0], data_lvl};
    end

    // Latch the two destination words and the shared gain bit.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            synth_control_word    <= slpp_pkg::WORD_RESET;
            feedback_divider_word <= slpp_pkg::WORD_RESET;
            pump_gain_select      <= 1'b0;
        end
        else if (ctrl_load)
        begin
            synth_control_word <= shift;
            pump_gain_select   <= shift[slpp_pkg::CB_GAIN];
        end
        else if (n_load)
        begin
            feedback_divider_word <= shift;
            pump_gain_select      <= shift[slpp_pkg::NB_GAIN];
        end
    end

    // Software power-down, immediate or gated to reference-divider edges.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_seen  <= 1'b0;
            sw_pd      <= 1'b0;
            pd_pending <= 1'b0;
            pd_edges   <= 2'h0;
        end
        else if (ctrl_load)
        begin
            ctrl_seen  <= 1'b1;
            sw_pd      <= new_arm & ~new_sync;
            pd_pending <= new_arm & new_sync;
            pd_edges   <= 2'h0;
        end
        else if (pd_pending & ref_rise)
        begin
            pd_edges <= pd_edges + 2'h1;
            if (ref_at_last)
            begin
                sw_pd      <= 1'b1;
                pd_pending <= 1'b0;
            end
        end
    end

    // Band selection runs for a fixed number of reference edges while powered.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            band_select_active <= 1'b0;
            band_count         <= 3'h0;
            band_valid         <= 1'b0;
            n_dirty            <= 1'b0;
            pd_prev            <= 1'b1;
        end
        else if (clk_en)
        begin
            pd_prev <= device_pd;
            if (n_load & device_pd)
                n_dirty <= 1'b1;
            if (band_start)
            begin
                band_select_active <= 1'b1;
                band_count         <= 3'h0;
                band_valid         <= 1'b0;
                n_dirty            <= 1'b0;
            end
            else if (device_pd)
                band_select_active <= 1'b0;
            else if (band_select_active & ref_rise)
            begin
                band_count <= band_count + 3'h1;
                if (band_count == slpp_pkg::BAND_CYCLES - 3'h1)
                begin
                    band_select_active <= 1'b0;
                    band_valid         <= 1'b1;
                end
            end
        end
    end

    // Registered data outputs derived from the stored words.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pump_current <= 3'h0;
            total_divide <= 19'h00000;
        end
        else if (clk_en)
        begin
            pump_current <= next_pump_current;
            total_divide <= next_total_divide;
        end
    end

    // Field views of the stored words.
    assign swallow_count = feedback_divider_word[slpp_pkg::NB_SWALLOW_LSB +: 5];
    assign main_count    = feedback_divider_word[slpp_pkg::NB_MAIN_LSB +: 13];
    assign main_count_valid      = main_count >= slpp_pkg::MAIN_MIN;
    assign output_halve          = feedback_divider_word[slpp_pkg::NB_HALVE];
    assign prescaler_input_halve = feedback_divider_word[slpp_pkg::NB_PRESC_HALVE];
    assign detector_polarity     = synth_control_word[slpp_pkg::CB_POLARITY];
    assign monitor_select   = synth_control_word[slpp_pkg::CB_MON_LSB +: 3];
    assign output_level     = synth_control_word[slpp_pkg::CB_LEVEL_LSB +: 2];
    assign core_current     = synth_control_word[slpp_pkg::CB_CORE_LSB +: 2];
    assign prescaler_select = synth_control_word[slpp_pkg::CB_PRESC_LSB +: 2];

    // Power-down consequences on the analog controls.
    assign powered_down      = device_pd;
    assign bias_enable       = ~device_pd;
    assign counters_hold     = device_pd | div_rst;
    assign pump_tristate     = device_pd | pump_tri;
    assign lock_detect_reset = device_pd;
    assign ref_buffer_enable = ~device_pd;
    assign rf_output_enable  = ~device_pd & (~mute_en | lock_lvl);

    // Checks on the latching and power logic.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_shift;
        sclk_rise |=> shift == {$past(shift[22:0]), $past(data_lvl)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift register mismatch");

    property p_ctrl;
        ctrl_load |=> synth_control_word == $past(shift);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control word not loaded");

    property p_ndiv;
        n_load |=> feedback_divider_word == $past(shift) && $stable(synth_control_word);
    endproperty
    a_ndiv: assert property (p_ndiv) else $error("feedback word not loaded");

    property p_gain;
        n_load |=> pump_gain_select == $past(shift[slpp_pkg::NB_GAIN]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain bit not latest");

    property p_async_pd;
        ctrl_load && new_arm && !new_sync |=> powered_down;
    endproperty
    a_async_pd: assert property (p_async_pd) else $error("no immediate power-down");

    property p_sync_pd;
        pd_pending && ref_at_last && !ctrl_load |=> sw_pd && !pd_pending;
    endproperty
    a_sync_pd: assert property (p_sync_pd) else $error("gated power-down missed");

    property p_sync_wait;
        ctrl_load && new_arm && new_sync |=> !sw_pd;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("gated power-down early");

    property p_ce;
        !ce_lvl |-> powered_down && !rf_output_enable;
    endproperty
    a_ce: assert property (p_ce) else $error("enable pin ignored");

    property p_pd_effects;
        powered_down |-> counters_hold && pump_tristate && lock_detect_reset
                         && !ref_buffer_enable && !bias_enable;
    endproperty
    a_pd_effects: assert property (p_pd_effects) else $error("power-down effects");

    property p_mute;
        mute_en && !lock_lvl |-> !rf_output_enable;
    endproperty
    a_mute: assert property (p_mute) else $error("output on before lock");

    property p_band;
        n_load && !device_pd |=> band_select_active && band_count == 3'h0;
    endproperty
    a_band: assert property (p_band) else $error("band select not restarted");

    property p_total;
        clk_en |=> total_divide == $past(next_total_divide);
    endproperty
    a_total: assert property (p_total) else $error("total division wrong");

    property p_current;
        clk_en && !ctrl_load && !n_load ##1 clk_en |=> pump_current == $past(next_pump_current);
    endproperty
    a_current: assert property (p_current) else $error("pump current select wrong");

    c_ctrl_load: cover property (ctrl_load);
    c_n_load:    cover property (n_load && !device_pd);
    c_sync_pd:   cover property (pd_pending ##[1:400] sw_pd);
    c_band_done: cover property (band_select_active ##1 !band_select_active && band_valid);
endmodule

// ===== tb/slpp_host_model.sv
`timescale 1ns/1ps
// Host controller on the three-wire programming link, clocked off the system clock.
module slpp_host_model (
    input  wire logic clk,
    output logic      serial_clk,
    output logic      serial_data,
    output logic      load_strobe
);
    // Control-to-divider settling interval, shortened so the run stays brief.
    localparam int SETTLE_CYCLES = 40;
    localparam int HALF_CYCLES   = 4;

    // The link clock stands low between frames and the strobe rests low.
    initial
    begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    // Shifts one word out most significant bit first, then pulses the strobe.
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            serial_data = w[i];
            repeat (HALF_CYCLES) @(negedge clk);
            serial_clk = 1'b1;
            repeat (HALF_CYCLES) @(negedge clk);
            serial_clk = 1'b0;
        end
        serial_data = ~w[0]; // Released line shows the inverse of the last bit.
        repeat (HALF_CYCLES) @(negedge clk);
        load_strobe = 1'b1;
        repeat (HALF_CYCLES) @(negedge clk);
        load_strobe = 1'b0;
    endtask

    // Waits out the settling interval between control and divider loads.
    task automatic settle();
        repeat (SETTLE_CYCLES) @(negedge clk);
    endtask
endmodule

// ===== tb/synth_latch_program_power_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the programming and power-management block.
module synth_latch_program_power_tb;
    localparam int LIMIT = 12000;
    localparam logic [23:0] CTRL_A = 24'h054104;
    localparam logic [23:0] NDIV_A = 24'h60641E;
    logic        clk, arst_n, clk_en, serial_clk, serial_data, load_strobe;
    logic        chip_enable, ref_div_out, lock_detect;
    logic [23:0] synth_control_word, feedback_divider_word;
    logic [18:0] total_divide;
    logic [12:0] main_count;
    logic [4:0]  swallow_count;
    logic [2:0]  pump_current, monitor_select;
    logic [1:0]  output_level, core_current, prescaler_select;
    logic        pump_gain_select, main_count_valid, output_halve, prescaler_input_halve;
    logic        detector_polarity, powered_down, bias_enable, counters_hold, pump_tristate;
    logic        lock_detect_reset, rf_output_enable, ref_buffer_enable, band_select_active;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;

    // Clock at 25 MHz.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    slpp_host_model host_u (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe));

    slpp_top dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe), .chip_enable(chip_enable),
        .ref_div_out(ref_div_out), .lock_detect(lock_detect),
        .synth_control_word(synth_control_word), .feedback_divider_word(feedback_divider_word),
        .pump_gain_select(pump_gain_select), .pump_current(pump_current),
        .total_divide(total_divide), .main_count_valid(main_count_valid),
        .swallow_count(swallow_count), .main_count(main_count), .output_halve(output_halve),
        .prescaler_input_halve(prescaler_input_halve), .detector_polarity(detector_polarity),
        .monitor_select(monitor_select), .output_level(output_level),
        .core_current(core_current), .prescaler_select(prescaler_select),
        .powered_down(powered_down), .bias_enable(bias_enable), .counters_hold(counters_hold),
        .pump_tristate(pump_tristate), .lock_detect_reset(lock_detect_reset),
        .rf_output_enable(rf_output_enable), .ref_buffer_enable(ref_buffer_enable),
        .band_select_active(band_select_active));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One reference-divider output period of eight system clocks.
    task automatic ref_pulse();
        ref_div_out = 1'b1;
        repeat (4) @(negedge clk);
        ref_div_out = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // Sends a word and lets the load land in the registers.
    task automatic load(input logic [23:0] w);
        host_u.send_word(w);
        repeat (8) @(negedge clk);
    endtask

    // Reset leaves every word clear and the device powered down.
    task automatic t_reset();
        chk(synth_control_word, 24'h000000, "ctrl reset");
        chk(feedback_divider_word, 24'h000000, "ndiv reset");
        chk({rf_output_enable, ref_buffer_enable, powered_down}, 24'h1, "pd reset");
    endtask

    // Reserved selects are ignored, then the control word powers the device up.
    task automatic t_select();
        load(24'h000005);
        load(24'hFFFFFF);
        chk(synth_control_word, 24'h000000, "select 01/11 stored");
        chk(powered_down, 1'b1, "up without control word");
        load(CTRL_A);
        chk(synth_control_word, CTRL_A, "ctrl word");
        chk({powered_down, bias_enable}, 24'h1, "ctrl load power-up");
        chk(pump_current, 3'h5, "primary current");
        chk(detector_polarity, 1'b1, "polarity");
        chk(core_current, 2'h1, "core current");
        chk(feedback_divider_word, 24'h000000, "ndiv from ctrl");
        chk(band_select_active, 1'b1, "band at power-up");
    endtask

    // Divider word fields, shared gain bit and band selection.
    task automatic t_ndiv();
        host_u.settle();
        load(NDIV_A);
        chk(feedback_divider_word, NDIV_A, "ndiv word");
        chk(swallow_count, 5'h07, "swallow");
        chk({main_count_valid, main_count}, 24'h2064, "main");
        chk(total_divide, 24'(slpp_pkg::PRESC_MOD0) * 24'h64 + 24'h7, "total");
        chk({prescaler_input_halve, output_halve}, 24'h1, "halving");
        chk({pump_gain_select, pump_current}, 24'hA, "gain from ndiv");
        chk(band_select_active, 1'b1, "band start");
        repeat (5) ref_pulse();
        chk(band_select_active, 1'b0, "band end");
        load(CTRL_A);
        chk({pump_gain_select, pump_current}, 24'h5, "gain from ctrl");
    endtask

    // Immediate power-down, control word still latches, return keeps the band.
    task automatic t_pd_async();
        load(CTRL_A | 24'h100000);
        chk(synth_control_word, CTRL_A | 24'h100000, "latch in pd");
        chk(powered_down, 1'b1, "async pd");
        chk({counters_hold, pump_tristate, lock_detect_reset}, 24'h7, "pd effects");
        chk({rf_output_enable, ref_buffer_enable}, 24'h0, "pd outputs");
        load(CTRL_A);
        chk({powered_down, band_select_active}, 24'h0, "no band restart");
    endtask

    // Gated power-down on the second reference edge.
    task automatic t_pd_sync();
        load(CTRL_A | 24'h300000);
        chk(powered_down, 1'b0, "sync pd early");
        ref_pulse();
        chk(powered_down, 1'b0, "sync pd first edge");
        ref_pulse();
        chk(powered_down, 1'b1, "sync pd second edge");
        load(CTRL_A);
        chk(powered_down, 1'b0, "sync pd cleared");
    endtask

    // Enable pin forces power-down whatever the bits hold.
    task automatic t_enable();
        chip_enable = 1'b0;
        repeat (6) @(negedge clk);
        chk({powered_down, ref_buffer_enable}, 24'h2, "enable low");
        chip_enable = 1'b1;
        repeat (6) @(negedge clk);
        chk(powered_down, 1'b0, "enable high");
        chk(band_select_active, 1'b0, "hw pd keeps band");
        // With the clock enable low the enable pin must not be seen at all.
        clk_en = 1'b0;
        chip_enable = 1'b0;
        repeat (6) @(negedge clk);
        chk(powered_down, 1'b0, "enable frozen");
        chip_enable = 1'b1;
        repeat (2) @(negedge clk);
        clk_en = 1'b1;
    endtask

    // Mute until lock, pump three-state and divider reset bits.
    task automatic t_mute();
        load(CTRL_A | 24'h403AB0);
        chk(rf_output_enable, 1'b0, "muted unlocked");
        chk(pump_tristate, 1'b1, "pump three-state");
        chk(counters_hold, 1'b1, "divider reset");
        lock_detect = 1'b1;
        repeat (6) @(negedge clk);
        chk(rf_output_enable, 1'b1, "unmuted locked");
        chk(monitor_select, 3'h5, "monitor select");
        chk(output_level, 2'h3, "output level");
        chk(prescaler_select, 2'h1, "prescaler select");
        chk(total_divide, 24'(slpp_pkg::PRESC_MOD1) * 24'h64 + 24'h7, "total code 1");
    endtask

    // Cuts a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            conclude();
        end
    end

    // Main sequence, inputs changed on the falling edge.
    initial
    begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        chip_enable = 1'b1;
        ref_div_out = 1'b0;
        lock_detect = 1'b0;
        repeat (20) @(negedge clk);
        t_reset();
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_select();
        t_ndiv();
        t_pd_async();
        t_pd_sync();
        t_enable();
        t_mute();
        conclude();
    end
endmodule
